// ===== rtl/pocs_top.sv
// Power-on sequencer: supply watch, configuration copy, pin release
`timescale 1ns/1ns
`include "pocs_cfg.svh"

module pocs_top #(
  parameter int unsigned T_CONFIG_CYC = `POCS_T_CONFIG_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_nrst,
  input  wire logic                        i_core_supply_ok,
  input  wire logic                        i_core_discharged,
  input  wire logic [`POCS_NUM_BANKS-1:0]  i_io_bank_supply_ok,
  input  wire logic                        i_clr_pin_option,
  input  wire logic                        i_global_register_clear_pin_n,
  input  wire logic                        i_oe_pin_option,
  input  wire logic                        i_global_output_enable_pin,
  input  wire logic [`POCS_CFG_DW-1:0]     i_nvm_data,
  output pocs_pkg::pocs_nvm_req_t          o_nvm,
  output pocs_pkg::pocs_cfg_wr_t           o_cfg,
  output pocs_pkg::pocs_pins_t             o_pins
);

  localparam int LATE_CYC = `POCS_LATE_IO_CYC;
  localparam int LATE_CHK = LATE_CYC + 1;

  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  pocs_pkg::pocs_mon_t  mon_raw;
  pocs_pkg::pocs_mon_t  mon;
  logic                 banks_all;
  logic                 clr_hold;
  logic                 oe_hold;

  // Every board-side level is asynchronous to the timebase
  assign mon_raw = {i_global_output_enable_pin, i_oe_pin_option,
                    i_global_register_clear_pin_n, i_clr_pin_option,
                    i_core_discharged, i_core_supply_ok,
                    i_io_bank_supply_ok};

  pocs_sync #(
    .W ($bits(pocs_pkg::pocs_mon_t))
  ) u_sync (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_async (mon_raw),
    .o_sync  (mon)
  );

  // Option pins only matter when their option is selected
  assign banks_all = &mon.bank_ok;
  assign clr_hold  = mon.clr_opt && !mon.clr_pin_n;
  assign oe_hold   = mon.oe_opt && !mon.oe_pin;

  // ---------------------------------------------------------------
  // State and counters
  // ---------------------------------------------------------------
  pocs_pkg::pocs_state_t   st_r;
  pocs_pkg::pocs_state_t   st_nxt;
  logic [`POCS_CFG_AW-1:0] cp_addr_r;
  logic [`POCS_CFG_AW-1:0] cp_addr_nxt;
  logic [`POCS_CLR_CW-1:0] clr_cnt_r;
  logic [`POCS_CLR_CW-1:0] clr_cnt_nxt;
  logic                    int_done;
  logic                    late_done;
  logic                    copy_last;
  logic                    clear_last;

  assign copy_last  = (cp_addr_r == `POCS_CFG_AW'(`POCS_CFG_WORDS - 1));
  assign clear_last = (clr_cnt_r == `POCS_CLR_CW'(`POCS_CLEAR_CYC - 1));

  // Interval from the start threshold; restarted by each new copy
  pocs_timer #(
    .LIMIT (T_CONFIG_CYC)
  ) u_int_tmr (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_clear (st_r == pocs_pkg::ST_OFF),
    .i_run   (1'b1),
    .o_done  (int_done)
  );

  // Late-bank delay restarts whenever any bank drops again
  pocs_timer #(
    .LIMIT (LATE_CYC)
  ) u_late_tmr (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_clear ((st_r != pocs_pkg::ST_LATE) || !banks_all),
    .i_run   (1'b1),
    .o_done  (late_done)
  );

  // ---------------------------------------------------------------
  // Sequencer next state
  // ---------------------------------------------------------------
  always_comb
  begin
    st_nxt      = st_r;
    cp_addr_nxt = cp_addr_r;
    clr_cnt_nxt = clr_cnt_r;
    case (st_r)
      pocs_pkg::ST_OFF:
      begin
        cp_addr_nxt = '0;
        clr_cnt_nxt = '0;
        if (mon.core_ok && !mon.core_dis)
        begin
          st_nxt = pocs_pkg::ST_COPY;
        end
      end
      pocs_pkg::ST_COPY:
      begin
        cp_addr_nxt = cp_addr_r + `POCS_CFG_AW'(1);
        if (copy_last)
        begin
          st_nxt = pocs_pkg::ST_CLEAR;
        end
      end
      pocs_pkg::ST_CLEAR:
      begin
        clr_cnt_nxt = clr_cnt_r + `POCS_CLR_CW'(1);
        if (clear_last)
        begin
          st_nxt = pocs_pkg::ST_WAIT;
        end
      end
      pocs_pkg::ST_WAIT:
      begin
        if (banks_all)
        begin
          st_nxt = pocs_pkg::ST_USER;
        end
        else if (int_done)
        begin
          st_nxt = pocs_pkg::ST_LATE;
        end
      end
      pocs_pkg::ST_LATE:
      begin
        if (late_done && banks_all)
        begin
          st_nxt = pocs_pkg::ST_USER;
        end
      end
      pocs_pkg::ST_USER:
      begin
        // Supplies are no longer watched; only a full discharge ends it
        if (mon.core_dis)
        begin
          st_nxt = pocs_pkg::ST_OFF;
        end
      end
      default:
      begin
        st_nxt = pocs_pkg::ST_OFF;
      end
    endcase
    // Before user mode a core drop aborts the load
    if ((st_r != pocs_pkg::ST_USER) && (!mon.core_ok || mon.core_dis))
    begin
      st_nxt = pocs_pkg::ST_OFF;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st_r      <= pocs_pkg::ST_OFF;
      cp_addr_r <= '0;
      clr_cnt_r <= '0;
    end
    else
    begin
      st_r      <= st_nxt;
      cp_addr_r <= cp_addr_nxt;
      clr_cnt_r <= clr_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Configuration copy datapath
  // ---------------------------------------------------------------
  pocs_pkg::pocs_cfg_wr_t  cfg_r;
  pocs_pkg::pocs_cfg_wr_t  cfg_nxt;

  // Store answers in the same cycle; the write lands one cycle later
  always_comb
  begin
    o_nvm.rd     = (st_r == pocs_pkg::ST_COPY);
    o_nvm.addr   = cp_addr_r;
    cfg_nxt.wr   = o_nvm.rd;
    cfg_nxt.addr = cp_addr_r;
    cfg_nxt.data = o_nvm.rd ? i_nvm_data : '0;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cfg_r <= '0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  assign o_cfg = cfg_r;

  // ---------------------------------------------------------------
  // Pin and clear control
  // ---------------------------------------------------------------
  pocs_pkg::pocs_pins_t  pins_r;
  pocs_pkg::pocs_pins_t  pins_nxt;
  logic                  user_nxt;

  // Registered from the next state so pins and state stay aligned
  always_comb
  begin
    user_nxt           = (st_nxt == pocs_pkg::ST_USER);
    pins_nxt.user_mode = user_nxt;
    pins_nxt.io_oe_n   = !user_nxt || oe_hold;
    pins_nxt.pullup_en = !user_nxt;
    // Clear spans the off, copy and clear phases and, unless the clear pin holds it, ends at least one cycle before pins can be released
    pins_nxt.reg_clear = (st_nxt == pocs_pkg::ST_OFF)
                      || (st_nxt == pocs_pkg::ST_COPY)
                      || (st_nxt == pocs_pkg::ST_CLEAR)
                      || clr_hold;
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pins_r <= pocs_pkg::pocs_pins_t'(`POCS_PINS_RST);
    end
    else
    begin
      pins_r <= pins_nxt;
    end
  end

  assign o_pins = pins_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [`POCS_LATE_HW-1:0]  late_h_r;
  logic [`POCS_LATE_HW-1:0]  late_h_nxt;

  // Consecutive cycles with all banks good while waiting late
  always_comb
  begin
    late_h_nxt = '0;
    if ((st_r == pocs_pkg::ST_LATE) && banks_all)
    begin
      late_h_nxt = (late_h_r == `POCS_LATE_HMAX) ? late_h_r
                 : late_h_r + `POCS_LATE_HW'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      late_h_r <= '0;
    end
    else
    begin
      late_h_r <= late_h_nxt;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  pin_hold_a: assert property (
    !o_pins.user_mode |-> (o_pins.io_oe_n && o_pins.pullup_en))
    else $error("pins not held tri-stated before user mode");
  pin_release_a: assert property (
    !o_pins.io_oe_n |-> o_pins.user_mode)
    else $error("pins driven outside user mode");
  copy_start_a: assert property (
    (st_r == pocs_pkg::ST_OFF && mon.core_ok && !mon.core_dis)
    |=> (st_r == pocs_pkg::ST_COPY) ##1 o_cfg.wr)
    else $error("copy did not start at the core threshold");
  early_entry_a: assert property (
    (st_r == pocs_pkg::ST_WAIT && banks_all && mon.core_ok
     && !mon.core_dis) |=> o_pins.user_mode)
    else $error("user mode not entered within interval");
  bank_gate_a: assert property (
    $rose(o_pins.user_mode) |-> $past(banks_all))
    else $error("user mode entered with a bank unpowered");
  late_delay_a: assert property (
    ($rose(o_pins.user_mode) && $past(st_r == pocs_pkg::ST_LATE))
    |-> (late_h_r == `POCS_LATE_HW'(LATE_CHK)))
    else $error("late-bank entry delay wrong");
  no_monitor_a: assert property (
    (o_pins.user_mode && !mon.core_dis) |=> o_pins.user_mode)
    else $error("user mode left without discharge");
  restart_a: assert property (
    (st_r == pocs_pkg::ST_USER && mon.core_dis)
    |=> (st_r == pocs_pkg::ST_OFF) ##1 o_pins.io_oe_n)
    else $error("discharge did not restart the sequence");
  clear_first_a: assert property (
    (st_r == pocs_pkg::ST_CLEAR) |-> (o_pins.reg_clear && o_pins.io_oe_n))
    else $error("clear phase overlapped pin release");
  clr_pin_a: assert property (
    (o_pins.user_mode && $past(clr_hold)) |-> o_pins.reg_clear)
    else $error("clear pin hold not honoured");
  oe_pin_a: assert property (
    $past(oe_hold) |-> o_pins.io_oe_n)
    else $error("output enable pin hold not honoured");

  early_cov: cover property (
    (st_r == pocs_pkg::ST_WAIT) ##1 o_pins.user_mode);
  late_cov: cover property (
    (st_r == pocs_pkg::ST_LATE) ##1 o_pins.user_mode);
  restart_cov: cover property (
    o_pins.user_mode ##1 (st_r == pocs_pkg::ST_OFF));

endmodule

// ===== rtl/pocs_cfg.svh
// Constants for the power-on configuration sequencer
`ifndef POCS_CFG_SVH
`define POCS_CFG_SVH

// ---------------------------------------------------------------
// Timebase
// ---------------------------------------------------------------
`define POCS_CLK_PERIOD_NS  50
`define POCS_NS_PER_US      1000

// ---------------------------------------------------------------
// Timing figures, in their own unit
// ---------------------------------------------------------------
`define POCS_T_CONFIG_US    450
`define POCS_T_LATE_IO_US   2

// Longest interval rounds down, least delay rounds up
`define POCS_T_CONFIG_CYC \
  ((`POCS_T_CONFIG_US * `POCS_NS_PER_US) / `POCS_CLK_PERIOD_NS)
`define POCS_LATE_IO_CYC \
  ((`POCS_T_LATE_IO_US * `POCS_NS_PER_US + `POCS_CLK_PERIOD_NS - 1) \
   / `POCS_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Structure
// ---------------------------------------------------------------
`define POCS_NUM_BANKS      4
`define POCS_CFG_WORDS      64
`define POCS_CFG_AW         6
`define POCS_CFG_DW         16
`define POCS_CLEAR_CYC      4
`define POCS_CLR_CW         3
`define POCS_LATE_HW        7
`define POCS_LATE_HMAX      7'h7f

// Pin-state reset: tri-stated, pulled up, clearing, not in user mode
`define POCS_PINS_RST       4'he

`endif

// ===== rtl/pocs_pkg.sv
// Types shared by the power-on configuration sequencer
`include "pocs_cfg.svh"

package pocs_pkg;

  // Synchronised monitor inputs, one bit each except bank_ok, which has one bit per bank
  typedef struct packed {
    logic                        oe_pin;
    logic                        oe_opt;
    logic                        clr_pin_n;
    logic                        clr_opt;
    logic                        core_dis;
    logic                        core_ok;
    logic [`POCS_NUM_BANKS-1:0]  bank_ok;
  } pocs_mon_t;

  // Read port towards the nonvolatile store
  typedef struct packed {
    logic                     rd;
    logic [`POCS_CFG_AW-1:0]  addr;
  } pocs_nvm_req_t;

  // Write port towards the volatile configuration cells
  typedef struct packed {
    logic                     wr;
    logic [`POCS_CFG_AW-1:0]  addr;
    logic [`POCS_CFG_DW-1:0]  data;
  } pocs_cfg_wr_t;

  // Device-wide pin and register control
  typedef struct packed {
    logic  io_oe_n;
    logic  pullup_en;
    logic  reg_clear;
    logic  user_mode;
  } pocs_pins_t;

  typedef enum logic [5:0] {
    ST_OFF   = 6'b00_0001,
    ST_COPY  = 6'b00_0010,
    ST_CLEAR = 6'b00_0100,
    ST_WAIT  = 6'b00_1000,
    ST_LATE  = 6'b01_0000,
    ST_USER  = 6'b10_0000
  } pocs_state_t;

endpackage

// ===== rtl/pocs_sync.sv
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns

module pocs_sync #(
  parameter int W = 1
) (
  input  wire logic          i_clk,
  input  wire logic          i_nrst,
  input  wire logic [W-1:0]  i_async,
  output logic      [W-1:0]  o_sync
);

  logic [W-1:0]  s1_r;
  logic [W-1:0]  s2_r;
  logic [W-1:0]  s3_r;
  logic [W-1:0]  out_r;
  logic [W-1:0]  out_nxt;

  // ---------------------------------------------------------------
  // Accept a change only when stages two and three agree
  // ---------------------------------------------------------------
  always_comb
  begin
    for (int b = 0; b < W; b++)
    begin
      out_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : out_r[b];
    end
  end

  // Stage one feeds stage two only, to keep metastability contained
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end
    else
    begin
      s1_r  <= i_async;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign o_sync = out_r;

endmodule

// ===== rtl/pocs_timer.sv
// Saturating cycle counter with a done level
`timescale 1ns/1ns

module pocs_timer #(
  parameter int unsigned LIMIT = 1
) (
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  input  wire logic  i_clear,
  input  wire logic  i_run,
  output logic       o_done
);

  localparam int W = $clog2(LIMIT + 1);

  logic [W-1:0]  cnt_r;
  logic [W-1:0]  cnt_nxt;

  // ---------------------------------------------------------------
  // Count up while running, hold at the limit
  // ---------------------------------------------------------------
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (i_clear)
    begin
      cnt_nxt = '0;
    end
    else if (i_run && !o_done)
    begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  assign o_done = (cnt_r == W'(LIMIT));

endmodule

// ===== dv/pocs_board_model.sv
// Board model: supply rails, option pins and the configuration store
`timescale 1ns/1ns
`include "pocs_cfg.svh"

module pocs_board_model #(
  parameter int DISCH_CYC = 200
) (
  input  wire logic                     i_clk,
  input  wire pocs_pkg::pocs_nvm_req_t  i_nvm,
  output logic [`POCS_CFG_DW-1:0]       o_nvm_data,
  output logic                          o_core_ok,
  output logic                          o_core_dis,
  output logic [`POCS_NUM_BANKS-1:0]    o_bank_ok,
  output logic                          o_clr_opt,
  output logic                          o_clr_n,
  output logic                          o_oe_opt,
  output logic                          o_oe
);
  // ---------------------------------------------------------------
  // Store and idle levels
  // ---------------------------------------------------------------
  // Unread store shows the inverse word, so a stale read cannot pass
  always_comb
  begin
    o_nvm_data = {~i_nvm.addr, 4'h5, i_nvm.addr};
    if (i_nvm.rd !== 1'b1)
      o_nvm_data = ~o_nvm_data;
  end

  // Board starts fully unpowered, option pins not selected
  initial
  begin
    o_core_ok = 1'b0;
    o_core_dis = 1'b0;
    o_bank_ok = 4'h0;
    o_clr_opt = 1'b0;
    o_clr_n = 1'b1;
    o_oe_opt = 1'b0;
    o_oe = 1'b1;
  end

  // ---------------------------------------------------------------
  // Board actions, all launched just after a rising edge
  // ---------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Rails may come up in any order and at any time
  task automatic rails(input logic core, input logic [3:0] banks);
    step(1);
    o_core_ok = core;
    o_bank_ok = banks;
  endtask

  // Option pins are held by the board as long as it wants
  task automatic opts(input logic c_opt, c_n, e_opt, e);
    step(1);
    o_clr_opt = c_opt;
    o_clr_n = c_n;
    o_oe_opt = e_opt;
    o_oe = e;
  endtask

  // Sag recovery: core held at discharge level for 10 us, then back up
  task automatic brown_out();
    step(1);
    o_core_ok = 1'b0;
    o_bank_ok = 4'h0;
    step(5);
    o_core_dis = 1'b1;
    step(DISCH_CYC);
    o_core_dis = 1'b0;
    step(5);
    o_core_ok = 1'b1;
    o_bank_ok = 4'hf;
  endtask
endmodule

// ===== dv/pocs_tb.sv
// Self-checking bench for the power-on configuration sequencer
`timescale 1ns/1ns
`include "pocs_cfg.svh"

module tb;
  // Short interval keeps the run brief; still longer than copy plus clear
  localparam int unsigned TCFG = 200;
  localparam int          LATE = `POCS_LATE_IO_CYC;

  logic                            i_clk;
  logic                            i_nrst;
  logic [`POCS_CFG_DW-1:0]         nvm_data;
  logic                            core_ok;
  logic                            core_dis;
  logic [`POCS_NUM_BANKS-1:0]      bank_ok;
  logic                            clr_opt;
  logic                            clr_n;
  logic                            oe_opt;
  logic                            oe;
  pocs_pkg::pocs_nvm_req_t         nvm;
  pocs_pkg::pocs_cfg_wr_t          cfg;
  pocs_pkg::pocs_pins_t            pins;
  int                              err_count;
  int                              n_compared;

  // ---------------------------------------------------------------
  // Clock, design and board
  // ---------------------------------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  pocs_top #(.T_CONFIG_CYC(TCFG)) dut (
    .i_clk                         (i_clk),
    .i_nrst                        (i_nrst),
    .i_core_supply_ok              (core_ok),
    .i_core_discharged             (core_dis),
    .i_io_bank_supply_ok           (bank_ok),
    .i_clr_pin_option              (clr_opt),
    .i_global_register_clear_pin_n (clr_n),
    .i_oe_pin_option               (oe_opt),
    .i_global_output_enable_pin    (oe),
    .i_nvm_data                    (nvm_data),
    .o_nvm                         (nvm),
    .o_cfg                         (cfg),
    .o_pins                        (pins)
  );

  pocs_board_model board (
    .i_clk      (i_clk),
    .i_nvm      (nvm),
    .o_nvm_data (nvm_data),
    .o_core_ok  (core_ok),
    .o_core_dis (core_dis),
    .o_bank_ok  (bank_ok),
    .o_clr_opt  (clr_opt),
    .o_clr_n    (clr_n),
    .o_oe_opt   (oe_opt),
    .o_oe       (oe)
  );

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Independent picture of the stored word at address k
  function automatic logic [15:0] exp_word(input int k);
    logic [5:0] a;
    a = k[5:0];
    return {~a, 4'h5, a};
  endfunction

  // Board down, reset held six cycles; the power-up path needs no reset
  task automatic do_reset();
    board.rails(1'b0, 4'h0);
    board.opts(1'b0, 1'b1, 1'b0, 1'b1);
    i_nrst = 1'b0;
    tick(6);
    i_nrst = 1'b1;
  endtask

  // Follow the sequence to user mode, judging every copied word
  task automatic run_to_user(input int bound, output int cyc, nwr,
                             output logic clr_prev);
    nwr = 0;
    clr_prev = 1'bx;
    for (cyc = 0; cyc < bound && pins.user_mode !== 1'b1; cyc++)
    begin
      check("pins held", 2'b11, {pins.io_oe_n, pins.pullup_en});
      if (cfg.wr === 1'b1)
      begin
        check("cfg addr", nwr, cfg.addr);
        check("cfg data", exp_word(nwr), cfg.data);
        nwr++;
      end
      clr_prev = pins.reg_clear;
      tick(1);
    end
    if (cyc == bound)
    begin
      err_count++;
      $display("mismatch user mode wait expected 1 seen 0");
      give_verdict();
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, and no copy while only the banks are up
  task automatic t_reset();
    do_reset();
    check("reset pins", 4'he, pins);
    board.rails(1'b0, 4'hf);
    tick(20);
    check("no copy", 2'b00, {nvm.rd, cfg.wr});
    check("idle pins", 4'he, pins);
  endtask

  // All rails together: full copy, clear, release, then supplies ignored
  task automatic t_together();
    int   cyc;
    int   nwr;
    logic clr;
    board.rails(1'b1, 4'hf);
    run_to_user(TCFG + 20, cyc, nwr, clr);
    check("words copied", 64, nwr);
    check("in interval", 1'b1, cyc <= TCFG + 6);
    check("clear first", 1'b0, clr);
    check("released", 4'h1, pins);
    board.rails(1'b0, 4'h0);
    tick(30);
    check("user kept", 4'h1, pins);
  endtask

  // Discharge and power up again: the copy runs once more from the start
  task automatic t_brownout();
    int   cyc;
    int   nwr;
    logic clr;
    board.brown_out();
    run_to_user(TCFG + 20, cyc, nwr, clr);
    check("recopied", 64, nwr);
    check("full again", 1'b1, cyc >= 68);
    check("released", 4'h1, pins);
  endtask

  // Banks late past the interval, one bank flickers before settling
  task automatic t_late();
    int   cyc;
    int   nwr;
    logic clr;
    do_reset();
    board.rails(1'b1, 4'h7);
    tick(TCFG + 40);
    check("late wait", 4'hc, pins);
    board.rails(1'b1, 4'hf);
    tick(20);
    board.rails(1'b1, 4'hb);
    tick(6);
    board.rails(1'b1, 4'hf);
    run_to_user(LATE + 20, cyc, nwr, clr);
    check("late delay", 1'b1, cyc >= LATE && cyc <= LATE + 8);
    check("late released", 4'h1, pins);
  endtask

  // Option pins hold the outputs and the clear beyond user-mode entry
  task automatic t_options();
    int   cyc;
    int   nwr;
    logic clr;
    do_reset();
    board.opts(1'b1, 1'b0, 1'b1, 1'b0);
    board.rails(1'b1, 4'hf);
    run_to_user(TCFG + 20, cyc, nwr, clr);
    tick(30);
    check("both held", 2'b11, {pins.io_oe_n, pins.reg_clear});
    board.opts(1'b1, 1'b0, 1'b1, 1'b1);
    tick(8);
    check("oe freed", 2'b01, {pins.io_oe_n, pins.reg_clear});
    board.opts(1'b1, 1'b1, 1'b1, 1'b1);
    tick(8);
    check("clear freed", 1'b0, pins.reg_clear);
  endtask

  // Core drop mid-copy aborts; the next rise copies again from word zero
  task automatic t_abort();
    int   cyc;
    int   nwr;
    logic clr;
    do_reset();
    board.rails(1'b1, 4'hf);
    tick(30);
    board.rails(1'b0, 4'hf);
    tick(10);
    check("aborted pins", 4'he, pins);
    check("aborted copy", 2'h0, {nvm.rd, cfg.wr});
    board.rails(1'b1, 4'hf);
    run_to_user(TCFG + 20, cyc, nwr, clr);
    check("abort recopy", 64, nwr);
    check("abort released", 4'h1, pins);
  endtask

  // Main sequence
  initial
  begin
    i_nrst = 1'b0;
    err_count = 0;
    n_compared = 0;
    t_reset();
    t_together();
    t_brownout();
    t_late();
    t_abort();
    t_options();
    give_verdict();
  end
endmodule
